/* acl_defs.svh */
// Offsets, field positions, reset values and timing figures of the clock control block
`ifndef ACL_DEFS_SVH
`define ACL_DEFS_SVH

`define ACL_ADDR_W              7
`define ACL_DATA_W              16
`define ACL_OFS_DIVIDERS        7'h0c
`define ACL_OFS_RATIO_RATE      7'h0d
`define ACL_OFS_SOURCE_GATING   7'h0e
`define ACL_OFS_LOOP_CTRL_A     7'h10
`define ACL_OFS_LOOP_CTRL_B     7'h11

`define ACL_OUTDIV_MSB          12
`define ACL_OUTDIV_LSB          10
`define ACL_TORATE_MSB          9
`define ACL_TORATE_LSB          8
`define ACL_RATIO_MSB           7
`define ACL_RATIO_LSB           4
`define ACL_RATE_MSB            3
`define ACL_RATE_LSB            0
`define ACL_SRC_BIT             13
`define ACL_DIVIDED_OUTPUT_CLOCK_EN_BIT        5
`define ACL_SLOW_TIMEOUT_CLOCK_EN_BIT        2
`define ACL_DSP_EN_BIT          1
`define ACL_SYS_EN_BIT          0
`define ACL_HOLD_BIT            3
`define ACL_FRAC_BIT            2
`define ACL_LOOP_EN_BIT         0
`define ACL_LOOPDIV_MSB         10
`define ACL_LOOPDIV_LSB         8

`define ACL_RST_DIVIDERS        16'h0000
`define ACL_RST_RATIO_RATE      16'h0038
`define ACL_RST_SOURCE_GATING   16'h0000
`define ACL_RST_LOOP_CTRL_A     16'h0000
`define ACL_RST_LOOP_CTRL_B     16'h0200

`define ACL_DIVIDERS_MASK       16'h1f00
`define ACL_RATIO_RATE_MASK     16'h00ff
`define ACL_SOURCE_GATING_MASK  16'h2027
`define ACL_LOOP_CTRL_A_MASK    16'h000d
`define ACL_LOOP_CTRL_B_MASK    16'h0700

`define ACL_MCLK_HZ             10000000
`define ACL_TO_HZ_0             125
`define ACL_TO_HZ_1             250
`define ACL_TO_HZ_2             500
`define ACL_TO_HZ_3             1000
`define ACL_CNT_W               17

`endif

/* acl_pkg.sv */
// Types shared by the clock control block
package acl_pkg;
    typedef enum logic {
        ACL_SRC_MCLK,
        ACL_SRC_LOOP
    } acl_source_t;

    typedef logic [10:0] acl_ratio_t;
    typedef logic [16:0] acl_rate_hz_t;
endpackage

/* acl_div_if.sv */
// Interface between the control logic and one clock divider
`timescale 1ns/1ps
interface acl_div_if #(
    parameter int W = 17
);
    logic         enable;
    logic         tick;
    logic [W-1:0] divisor;
    logic         level;
    logic         pulse;

    modport ctrl (output enable, output tick, output divisor, input level, input pulse);
    modport div  (input enable, input tick, input divisor, output level, output pulse);
endinterface

/* acl_clock_divider.sv */
// Tick-driven divider producing a half-duty level and a one-cycle period pulse
`timescale 1ns/1ps
module acl_clock_divider #(
    parameter int W = 17
) (
    input wire logic mclk,
    input wire logic rst_n,
    acl_div_if.div   bus
);
    logic [W-1:0] count;
    logic         lastCount;
    logic [W-1:0] halfDiv;

    assign lastCount = (count >= bus.divisor - W'(1));
    assign halfDiv   = bus.divisor >> 1;

    // Period counter, restarts while disabled
    always_ff @(posedge mclk) begin
        if (!rst_n || !bus.enable) begin
            count <= '0;
        end else if (bus.tick) begin
            count <= lastCount ? '0 : count + W'(1);
        end
    end

    // Level high over the first half of each period
    always_ff @(posedge mclk) begin
        if (!rst_n || !bus.enable) begin
            bus.level <= 1'b0;
        end else if (bus.tick) begin
            bus.level <= (bus.divisor <= W'(1)) ? 1'b1 : (count < halfDiv);
        end
    end

    // One pulse at the start of each period
    always_ff @(posedge mclk) begin
        if (!rst_n) begin
            bus.pulse <= 1'b0;
        end else begin
            bus.pulse <= bus.enable && bus.tick && (count == '0);
        end
    end
endmodule

/* audio_clock_and_loop_control.sv */
// Clock ratio, rate select, source select, gating and locked-loop control
`timescale 1ns/1ps
`include "acl_defs.svh"

// How it works
// - Bits 7:4 pick system clocks per sample, 64 up to 1536, reset 0011.
// - Bits 3:0 pick sample rate 8 to 96 kHz, reset 1000.
// - Bit 5 drives the master clock pin, carrying the divided output clock only while bit 0 is also set.
// - Slow timeout clock runs only while bit 2 is set; off after reset.
// - Hold bit keeps the loop free-running when its reference disappears.
// - Loop bit 2 picks integer (0) or fractional (1) multiply; fractional advised.
// - Loop output divider bits 10:8, 000 divides by 2, 001 by 4, reset 010.
// - Codes 010 to 111 divide by 8 up to 256.
// - Bits 9:8 pick slow clock 125 Hz, 250 Hz, 500 Hz or 1 kHz.
module audio_clock_and_loop_control #(
    parameter int TO_COUNT_0 = `ACL_MCLK_HZ / `ACL_TO_HZ_0,
    parameter int TO_COUNT_1 = `ACL_MCLK_HZ / `ACL_TO_HZ_1,
    parameter int TO_COUNT_2 = `ACL_MCLK_HZ / `ACL_TO_HZ_2,
    parameter int TO_COUNT_3 = `ACL_MCLK_HZ / `ACL_TO_HZ_3
) (
    input  wire logic                       mclk,
    input  wire logic                       rst_n,
    input  wire logic [`ACL_ADDR_W-1:0]     regAddr,
    input  wire logic [`ACL_DATA_W-1:0]     regWrData,
    input  wire logic                       regWrEn,
    output logic      [`ACL_DATA_W-1:0]     regRdData,
    input  wire logic                       loopOscTick,
    input  wire logic                       loopReferencePresent,
    output logic                            mclkPinOut,
    output logic                            mclkPinDrive_n,
    output logic                            systemClockTick,
    output logic                            processingClockTick,
    output logic                            slowTimeoutClock,
    output logic                            frequencyLockedLoopOut,
    output logic                            loopRunning,
    output logic                            loopFractionalMode,
    output acl_pkg::acl_source_t            sysclkSourceSelect,
    output acl_pkg::acl_ratio_t             sysclkPerSampleRatio,
    output acl_pkg::acl_rate_hz_t           sampleRateHz,
    output logic                            sampleRateReserved
);
    logic [`ACL_DATA_W-1:0] dividers;
    logic [`ACL_DATA_W-1:0] ratioRate;
    logic [`ACL_DATA_W-1:0] sourceGating;
    logic [`ACL_DATA_W-1:0] loopCtrlA;
    logic [`ACL_DATA_W-1:0] loopCtrlB;
    logic [`ACL_DATA_W-1:0] next_regRdData;
    acl_pkg::acl_ratio_t    next_ratio;
    acl_pkg::acl_rate_hz_t  next_rateHz;
    logic                   loopActive;
    logic                   sourceTick;
    logic                   sysTick;
    logic [`ACL_CNT_W-1:0]  loopDivisor;
    logic [`ACL_CNT_W-1:0]  outDivisor;
    logic [`ACL_CNT_W-1:0]  toDivisor;

    acl_div_if #(.W(`ACL_CNT_W)) loopDiv ();
    acl_div_if #(.W(`ACL_CNT_W)) outDiv ();
    acl_div_if #(.W(`ACL_CNT_W)) toDiv ();

    // Register writes
    always_ff @(posedge mclk) begin
        if (!rst_n) begin
            dividers     <= `ACL_RST_DIVIDERS;
            ratioRate    <= `ACL_RST_RATIO_RATE;
            sourceGating <= `ACL_RST_SOURCE_GATING;
            loopCtrlA    <= `ACL_RST_LOOP_CTRL_A;
            loopCtrlB    <= `ACL_RST_LOOP_CTRL_B;
        end else if (regWrEn) begin
            unique case (regAddr)
                `ACL_OFS_DIVIDERS: begin
                    dividers <= regWrData & `ACL_DIVIDERS_MASK;
                end
                `ACL_OFS_RATIO_RATE: begin
                    ratioRate <= regWrData & `ACL_RATIO_RATE_MASK;
                end
                `ACL_OFS_SOURCE_GATING: begin
                    sourceGating <= regWrData & `ACL_SOURCE_GATING_MASK;
                end
                `ACL_OFS_LOOP_CTRL_A: begin
                    loopCtrlA <= regWrData & `ACL_LOOP_CTRL_A_MASK;
                end
                `ACL_OFS_LOOP_CTRL_B: begin
                    loopCtrlB <= regWrData & `ACL_LOOP_CTRL_B_MASK;
                end
                default: begin
                end
            endcase
        end
    end

    // Read mux, unmapped reads return zero
    always_comb begin
        unique case (regAddr)
            `ACL_OFS_DIVIDERS:      next_regRdData = dividers;
            `ACL_OFS_RATIO_RATE:    next_regRdData = ratioRate;
            `ACL_OFS_SOURCE_GATING: next_regRdData = sourceGating;
            `ACL_OFS_LOOP_CTRL_A:   next_regRdData = loopCtrlA;
            `ACL_OFS_LOOP_CTRL_B:   next_regRdData = loopCtrlB;
            default:                next_regRdData = 16'h0000;
        endcase
    end

    always_ff @(posedge mclk) begin
        if (!rst_n) begin
            regRdData <= 16'h0000;
        end else begin
            regRdData <= next_regRdData;
        end
    end

    // Ratio lookup
    always_comb begin
        unique case (ratioRate[`ACL_RATIO_MSB:`ACL_RATIO_LSB])
            4'h0:    next_ratio = 11'd64;
            4'h1:    next_ratio = 11'd128;
            4'h2:    next_ratio = 11'd192;
            4'h3:    next_ratio = 11'd256;
            4'h4:    next_ratio = 11'd384;
            4'h5:    next_ratio = 11'd512;
            4'h6:    next_ratio = 11'd768;
            4'h7:    next_ratio = 11'd1024;
            4'h8:    next_ratio = 11'd1408;
            4'h9:    next_ratio = 11'd1536;
            default: next_ratio = 11'd0;
        endcase
    end

    // Sample rate lookup, reserved codes flagged
    always_comb begin
        unique case (ratioRate[`ACL_RATE_MSB:`ACL_RATE_LSB])
            4'h0:    next_rateHz = 17'd8000;
            4'h1:    next_rateHz = 17'd11025;
            4'h2:    next_rateHz = 17'd12000;
            4'h3:    next_rateHz = 17'd16000;
            4'h4:    next_rateHz = 17'd22050;
            4'h5:    next_rateHz = 17'd24000;
            4'h6:    next_rateHz = 17'd32000;
            4'h7:    next_rateHz = 17'd44100;
            4'h8:    next_rateHz = 17'd48000;
            4'h9:    next_rateHz = 17'd88200;
            4'ha:    next_rateHz = 17'd96000;
            default: next_rateHz = 17'd0;
        endcase
    end

    always_ff @(posedge mclk) begin
        if (!rst_n) begin
            sysclkPerSampleRatio <= 11'd256;
            sampleRateHz         <= 17'd48000;
            sampleRateReserved   <= 1'b0;
        end else begin
            sysclkPerSampleRatio <= next_ratio;
            sampleRateHz         <= next_rateHz;
            sampleRateReserved   <= (ratioRate[`ACL_RATE_MSB:`ACL_RATE_LSB] > 4'ha);
        end
    end

    // Loop runs with reference, or free-runs on hold
    assign loopActive = loopCtrlA[`ACL_LOOP_EN_BIT]
                        && (loopReferencePresent || loopCtrlA[`ACL_HOLD_BIT]);

    // Loop output divisor is 2 to the power code plus one
    assign loopDivisor = `ACL_CNT_W'(2) << loopCtrlB[`ACL_LOOPDIV_MSB:`ACL_LOOPDIV_LSB];

    assign loopDiv.enable  = loopActive;
    assign loopDiv.tick    = loopOscTick;
    assign loopDiv.divisor = loopDivisor;

    acl_clock_divider #(.W(`ACL_CNT_W)) loopDivider (
        .mclk  (mclk),
        .rst_n (rst_n),
        .bus   (loopDiv)
    );

    // System clock source and gating
    assign sourceTick = (sysclkSourceSelect == acl_pkg::ACL_SRC_LOOP) ? loopDiv.pulse : 1'b1;
    assign sysTick    = sourceGating[`ACL_SYS_EN_BIT] && sourceTick;

    always_comb begin
        unique case (dividers[`ACL_OUTDIV_MSB:`ACL_OUTDIV_LSB])
            3'h0: outDivisor = `ACL_CNT_W'(1);
            3'h1: outDivisor = `ACL_CNT_W'(2);
            3'h2: outDivisor = `ACL_CNT_W'(3);
            3'h3: outDivisor = `ACL_CNT_W'(4);
            3'h4: outDivisor = `ACL_CNT_W'(6);
            3'h5: outDivisor = `ACL_CNT_W'(8);
            3'h6: outDivisor = `ACL_CNT_W'(12);
            3'h7: outDivisor = `ACL_CNT_W'(16);
        endcase
    end

    assign outDiv.enable  = sourceGating[`ACL_DIVIDED_OUTPUT_CLOCK_EN_BIT] && sourceGating[`ACL_SYS_EN_BIT];
    assign outDiv.tick    = sysTick;
    assign outDiv.divisor = outDivisor;

    acl_clock_divider #(.W(`ACL_CNT_W)) outDivider (
        .mclk  (mclk),
        .rst_n (rst_n),
        .bus   (outDiv)
    );

    always_comb begin
        unique case (dividers[`ACL_TORATE_MSB:`ACL_TORATE_LSB])
            2'h0: toDivisor = `ACL_CNT_W'(TO_COUNT_0);
            2'h1: toDivisor = `ACL_CNT_W'(TO_COUNT_1);
            2'h2: toDivisor = `ACL_CNT_W'(TO_COUNT_2);
            2'h3: toDivisor = `ACL_CNT_W'(TO_COUNT_3);
        endcase
    end

    assign toDiv.enable  = sourceGating[`ACL_SLOW_TIMEOUT_CLOCK_EN_BIT];
    assign toDiv.tick    = 1'b1;
    assign toDiv.divisor = toDivisor;

    acl_clock_divider #(.W(`ACL_CNT_W)) toDivider (
        .mclk  (mclk),
        .rst_n (rst_n),
        .bus   (toDiv)
    );

    assign slowTimeoutClock       = toDiv.level;
    assign frequencyLockedLoopOut = loopDiv.level;
    assign mclkPinOut             = outDiv.level;

    // Status and gated clock ticks
    always_ff @(posedge mclk) begin
        if (!rst_n) begin
            sysclkSourceSelect  <= acl_pkg::ACL_SRC_MCLK;
            mclkPinDrive_n      <= 1'b1;
            loopRunning         <= 1'b0;
            loopFractionalMode  <= 1'b0;
            systemClockTick     <= 1'b0;
            processingClockTick <= 1'b0;
        end else begin
            sysclkSourceSelect  <= sourceGating[`ACL_SRC_BIT] ? acl_pkg::ACL_SRC_LOOP
                                                               : acl_pkg::ACL_SRC_MCLK;
            mclkPinDrive_n      <= !sourceGating[`ACL_DIVIDED_OUTPUT_CLOCK_EN_BIT];
            loopRunning         <= loopActive;
            loopFractionalMode  <= loopCtrlA[`ACL_FRAC_BIT];
            systemClockTick     <= sysTick;
            processingClockTick <= sysTick && sourceGating[`ACL_DSP_EN_BIT];
        end
    end
endmodule

/* acl_properties.sv */
// Port-level concurrent checks for the clock control block
`timescale 1ns/1ps
`include "acl_defs.svh"
module acl_props (
    input wire logic                  mclk,
    input wire logic                  rst_n,
    input wire logic [6:0]            regAddr,
    input wire logic [15:0]           regWrData,
    input wire logic                  regWrEn,
    input wire logic                  loopReferencePresent,
    input wire logic                  mclkPinDrive_n,
    input wire logic                  systemClockTick,
    input wire logic                  processingClockTick,
    input wire logic                  slowTimeoutClock,
    input wire logic                  loopRunning,
    input wire logic                  loopFractionalMode,
    input wire acl_pkg::acl_source_t  sysclkSourceSelect,
    input wire acl_pkg::acl_ratio_t   sysclkPerSampleRatio,
    input wire acl_pkg::acl_rate_hz_t sampleRateHz,
    input wire logic                  sampleRateReserved
);
    localparam int RATIO[16] = '{64, 128, 192, 256, 384, 512, 768, 1024, 1408, 1536, 0, 0, 0, 0, 0, 0};
    localparam int RATE[16] = '{8000, 11025, 12000, 16000, 22050, 24000, 32000, 44100, 48000, 88200, 96000,
                                0, 0, 0, 0, 0};
    logic        wrG;
    logic [15:0] gate;
    logic [15:0] loopA;
    assign wrG = regWrEn && regAddr == `ACL_OFS_SOURCE_GATING;
    // Shadow of gating register
    always_ff @(posedge mclk) begin
        if (!rst_n) gate <= '0;
        else if (wrG) gate <= regWrData;
    end
    // Shadow of loop control
    always_ff @(posedge mclk) begin
        if (!rst_n) loopA <= '0;
        else if (regWrEn && regAddr == `ACL_OFS_LOOP_CTRL_A) loopA <= regWrData;
    end
    default clocking @(posedge mclk); endclocking
    default disable iff (!rst_n);
    property p_ratio;
        regWrEn && regAddr == `ACL_OFS_RATIO_RATE |-> ##2 sysclkPerSampleRatio == 11'(RATIO[$past(regWrData[7:4], 2)]);
    endproperty
    property p_rate;
        regWrEn && regAddr == `ACL_OFS_RATIO_RATE |-> ##2 sampleRateHz == 17'(RATE[$past(regWrData[3:0], 2)]);
    endproperty
    property p_src;
        wrG |-> ##2 sysclkSourceSelect == $past(regWrData[13], 2);
    endproperty
    property p_drive;
        wrG |-> ##2 mclkPinDrive_n == !$past(regWrData[5], 2);
    endproperty
    property p_slow;
        (!gate[2])[*3] |-> !slowTimeoutClock;
    endproperty
    property p_proc;
        processingClockTick |-> systemClockTick && (gate[1] || $past(gate[1]));
    endproperty
    property p_loop;
        $stable(loopA) |-> loopRunning == (loopA[0] && (loopA[3] || $past(loopReferencePresent)));
    endproperty
    property p_frac;
        $stable(loopA) |-> loopFractionalMode == loopA[2];
    endproperty
    a_ratio: assert property (p_ratio) else $error("ratio output wrong");
    a_rate: assert property (p_rate) else $error("rate output wrong");
    a_src: assert property (p_src) else $error("source select wrong");
    a_drive: assert property (p_drive) else $error("pin drive wrong");
    a_slow: assert property (p_slow) else $error("slow clock runs while off");
    a_proc: assert property (p_proc) else $error("processing tick while off");
    a_loop: assert property (p_loop) else $error("loop running wrong");
    a_frac: assert property (p_frac) else $error("fractional mode wrong");
    c_fast: cover property (sampleRateHz == 17'd96000);
    c_loop: cover property ($rose(loopRunning));
    c_pin: cover property ($fell(mclkPinDrive_n));
endmodule
bind audio_clock_and_loop_control acl_props u_props (.mclk, .rst_n, .regAddr, .regWrData, .regWrEn,
    .loopReferencePresent, .mclkPinDrive_n, .systemClockTick, .processingClockTick, .slowTimeoutClock,
    .loopRunning, .loopFractionalMode, .sysclkSourceSelect, .sysclkPerSampleRatio, .sampleRateHz,
    .sampleRateReserved);

/* audio_clock_and_loop_control_tb.sv */
// Self-checking bench for the clock control block
`timescale 1ns/1ps
`define CHK(g, e) begin comparisons++; if ((g) !== (e)) begin badCount++; $display("[ERR] %0t %h %h", $time, g, e); end end
module audio_clock_and_loop_control_tb;
    logic                  mclk, rst_n, regWrEn, loopOscTick, loopReferencePresent;
    logic [6:0]            regAddr;
    logic [15:0]           regWrData, regRdData;
    logic                  mclkPinOut, mclkPinDrive_n, systemClockTick, processingClockTick;
    logic                  slowTimeoutClock, frequencyLockedLoopOut, loopRunning, loopFractionalMode;
    logic                  sampleRateReserved;
    acl_pkg::acl_source_t  sysclkSourceSelect;
    acl_pkg::acl_ratio_t   sysclkPerSampleRatio;
    acl_pkg::acl_rate_hz_t sampleRateHz;
    int                    badCount = 0, comparisons = 0;
    audio_clock_and_loop_control #(.TO_COUNT_0(16), .TO_COUNT_1(8), .TO_COUNT_2(4), .TO_COUNT_3(2)) u_dut (
        .mclk, .rst_n, .regAddr, .regWrData, .regWrEn, .regRdData, .loopOscTick, .loopReferencePresent,
        .mclkPinOut, .mclkPinDrive_n, .systemClockTick, .processingClockTick, .slowTimeoutClock,
        .frequencyLockedLoopOut, .loopRunning, .loopFractionalMode, .sysclkSourceSelect,
        .sysclkPerSampleRatio, .sampleRateHz, .sampleRateReserved);
    initial begin
        mclk = 0;
        forever #50 mclk = ~mclk;
    end
    task automatic finishTest;
        $display("Mismatches %0d, checks %0d", badCount, comparisons);
        if (badCount == 0 && comparisons > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask
    task automatic doReset;
        rst_n = 0;
        repeat (5) @(posedge mclk);
        #1;
        rst_n = 1;
    endtask
    task automatic wr(input logic [6:0] a, input logic [15:0] d);
        @(posedge mclk);
        #1;
        regAddr = a;
        regWrData = d;
        regWrEn = 1;
        @(posedge mclk);
        #1;
        regWrEn = 0;
        repeat (2) @(posedge mclk);
        #1;
    endtask
    task automatic rdChk(input logic [6:0] a, input logic [15:0] e);
        regAddr = a;
        repeat (2) @(posedge mclk);
        #1;
        `CHK(regRdData, e)
    endtask
    function automatic logic sig(input int s);
        case (s)
            0: return mclkPinOut;
            1: return slowTimeoutClock;
            default: return frequencyLockedLoopOut;
        endcase
    endfunction
    task automatic waitLvl(input int s, input logic v, inout int n);
        while (sig(s) !== v) begin
            @(posedge mclk);
            #1;
            n++;
            if (n > 2000) begin
                badCount++;
                finishTest();
            end
        end
    endtask
    task automatic period(input int s, input int e);
        int n;
        n = 0;
        waitLvl(s, 0, n);
        waitLvl(s, 1, n);
        n = 0;
        waitLvl(s, 0, n);
        waitLvl(s, 1, n);
        `CHK(n, e)
    endtask
    task automatic regScenario;
        logic [6:0]  ad[6] = '{7'h0c, 7'h0d, 7'h0e, 7'h10, 7'h11, 7'h0f};
        logic [15:0] rv[6] = '{16'h0000, 16'h0038, 16'h0000, 16'h0000, 16'h0200, 16'h0000};
        logic [15:0] mk[6] = '{16'h1f00, 16'h00ff, 16'h2027, 16'h000d, 16'h0700, 16'h0000};
        repeat (20) begin
            @(posedge mclk);
            #1;
            `CHK(slowTimeoutClock | processingClockTick | systemClockTick | loopRunning | mclkPinOut, 1'b0)
        end
        for (int p = 0; p < 2; p++) begin
            for (int i = 0; i < 6; i++) rdChk(ad[i], rv[i]);
            `CHK(sysclkPerSampleRatio, 11'h100)
            `CHK(sampleRateHz, 17'h0_bb80)
            `CHK(mclkPinDrive_n, 1'b1)
            for (int i = 0; i < 6; i++) wr(ad[i], p ? 16'hfff8 : 16'hfff7);
            for (int i = 0; i < 6; i++) rdChk(ad[i], mk[i] & (p ? 16'hfff8 : 16'hfff7));
            doReset();
        end
    endtask
    task automatic tableScenario;
        int ra[16] = '{64, 128, 192, 256, 384, 512, 768, 1024, 1408, 1536, 0, 0, 0, 0, 0, 0};
        int rt[16] = '{8000, 11025, 12000, 16000, 22050, 24000, 32000, 44100, 48000, 88200, 96000, 0, 0, 0, 0, 0};
        for (int c = 0; c < 16; c++) begin
            wr(7'h0d, 16'((c << 4) | (c % 11)));
            `CHK(sysclkPerSampleRatio, 11'(ra[c]))
            `CHK(sampleRateHz, 17'(rt[c % 11]))
            `CHK(sampleRateReserved, 1'b0)
        end
    endtask
    task automatic gateScenario;
        wr(7'h0e, 16'h0001);
        `CHK(sysclkSourceSelect, acl_pkg::ACL_SRC_MCLK)
        `CHK(processingClockTick, 1'b0)
        `CHK(systemClockTick, 1'b1)
        wr(7'h0e, 16'h0003);
        `CHK(processingClockTick, 1'b1)
    endtask
    task automatic outClkScenario;
        int dv[8] = '{1, 2, 3, 4, 6, 8, 12, 16};
        wr(7'h0e, 16'h0021);
        `CHK(mclkPinDrive_n, 1'b0)
        `CHK(mclkPinOut, 1'b1)
        for (int c = 1; c < 8; c++) begin
            wr(7'h0c, 16'(c << 10));
            period(0, dv[c]);
        end
        wr(7'h0e, 16'h0001);
        `CHK(mclkPinDrive_n, 1'b1)
    endtask
    task automatic slowScenario;
        wr(7'h0e, 16'h0004);
        for (int k = 0; k < 4; k++) begin
            wr(7'h0c, 16'(k << 8));
            period(1, 16 >> k);
        end
    endtask
    task automatic loopScenario;
        int n = 0;
        loopOscTick = 1;
        wr(7'h10, 16'h0005);
        `CHK(loopFractionalMode, 1'b1)
        `CHK(loopRunning, 1'b1)
        for (int c = 0; c < 8; c++) begin
            wr(7'h11, 16'(c << 8));
            period(2, 2 << c);
        end
        wr(7'h0e, 16'h2001);
        `CHK(sysclkSourceSelect, acl_pkg::ACL_SRC_LOOP)
        repeat (512) begin
            @(posedge mclk);
            #1;
            n += systemClockTick;
        end
        `CHK(n, 2)
        loopReferencePresent = 0;
        repeat (3) @(posedge mclk);
        #1;
        `CHK(loopRunning, 1'b0)
        wr(7'h10, 16'h000d);
        `CHK(loopRunning, 1'b1)
        loopReferencePresent = 1;
    endtask
    initial begin
        rst_n = 0;
        regAddr = 7'h00;
        regWrData = 16'h0000;
        regWrEn = 0;
        loopOscTick = 0;
        loopReferencePresent = 1;
        doReset();
        regScenario();
        tableScenario();
        gateScenario();
        outClkScenario();
        slowScenario();
        loopScenario();
        finishTest();
    end
endmodule
